// ==== logic/acfc_pkg.sv ====
package acfc_pkg;
	// bit positions inside conversion_flow_control
	localparam int ACFC_BIT_ABORT = 7;
	localparam int ACFC_BIT_SEQUENCE_TRIGGER_REQUEST = 6;
	localparam int ACFC_BIT_RESTART = 5;
	localparam int ACFC_BIT_LOAD_OK = 4;
	localparam int ACFC_REG_W = 8;
	localparam logic [7:0] ACFC_REG_RESET = 8'h00;
	// request_source_select encoding: bit 0 data bus, bit 1 internal
	localparam int ACFC_SRC_BUS = 0;
	localparam int ACFC_SRC_HW = 1;
	// error flag positions in err_flags / err_clr
	localparam int ACFC_ERR_RESTART = 0;
	localparam int ACFC_ERR_SEQUENCE_TRIGGER_REQUEST = 1;
	localparam int ACFC_ERR_LOAD_OK = 2;
	localparam int ACFC_ERR_ABORT_OVR = 3;
	localparam int ACFC_ERR_W = 4;
	localparam logic [3:0] ACFC_ERR_RESET = 4'h0;
endpackage

// ==== logic/acfc_req_if.sv ====
`timescale 1ns/1ns
// one cycle of merged requests and the scenario verdict on them
interface acfc_req_if;
	logic restart;
	logic trigger;
	logic abort;
	logic load_ok;
	logic trigger_mode;
	logic take_trigger;
	logic trigger_error;
	logic load_ok_error;
	logic auto_trigger;
	modport ctrl (output restart, trigger, abort, load_ok, trigger_mode,
		input take_trigger, trigger_error, load_ok_error, auto_trigger);
	modport dec (input restart, trigger, abort, load_ok, trigger_mode,
		output take_trigger, trigger_error, load_ok_error, auto_trigger);
endinterface

// ==== logic/acfc_scenario_dec.sv ====
`timescale 1ns/1ns
// classifies the restart/trigger/abort/load_ok combination of one cycle
module acfc_scenario_dec
	import acfc_pkg::*;
(
	acfc_req_if.dec req
);
	// restart mode refuses a trigger that comes with a restart
	always_comb begin
		req.trigger_error = req.restart & req.trigger & ~req.trigger_mode; // [R14]
		req.take_trigger = req.trigger & ~req.trigger_error; // [R14]
		// trigger mode: restart alone also starts the sequence
		req.auto_trigger = req.restart & req.trigger_mode; // [R18]
		// load_ok without restart cannot happen; report it, unless aborted
		req.load_ok_error = req.load_ok & ~req.restart & ~req.abort; // [R15] [R17]
	end
endmodule

// ==== logic/acfc_flow_ctrl.sv ====
`timescale 1ns/1ns
// How it works
// R1: abort bit stops sequence at next boundary
// R2: abort bit clears once aborted and idle
// R3: abort and trigger need enable; cleared otherwise
// R4: source select picks bus or internal requests
// R5: writing zero never clears either bit
// R6: bus abort while set is overrun
// R7: internal abort while set is overrun
// R8: restart sets abort unless aborting or list ended
// R9: automatic abort raises restart error flag
// R10: trigger starts sequence when nothing runs
// R11: trigger clears when first conversion samples
// R12: bus trigger while set raises trigger error
// R13: internal trigger while set raises trigger error
// R14: restart mode: restart plus trigger is error
// R15: load-ok alone flagged; other combinations valid (code also flags load-ok with trigger but no restart or abort)
// R16: restart fetches top; load-ok swaps lists first
// R17: abort with restart suppresses restart/load-ok errors
// R18: trigger mode restart sets trigger bit
module acfc_flow_ctrl
	import acfc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic adc_en,
	input wire logic [1:0] request_source_select,
	input wire logic trigger_mode,
	input wire logic wr_en,
	input wire logic [ACFC_REG_W-1:0] wr_data,
	input wire logic sequence_abort_request,
	input wire logic sequence_trigger_request,
	input wire logic list_restart_request,
	input wire logic list_load_ok,
	input wire logic conv_boundary,
	input wire logic conv_idle,
	input wire logic seq_active,
	input wire logic first_sample,
	input wire logic abort_in_progress,
	input wire logic end_of_list_reached,
	input wire logic [ACFC_ERR_W-1:0] err_clr,
	output logic [ACFC_REG_W-1:0] rd_data,
	output logic [ACFC_ERR_W-1:0] err_flags,
	output logic seq_abort_cmd,
	output logic seq_start,
	output logic fetch_top,
	output logic swap_list
);
	// merged requests travel to the scenario decoder through one bundle
	acfc_req_if req ();

	// architectural bits and their progress markers
	logic abort_ff, nxt_abort;
	logic aborted_ff, nxt_aborted;
	logic sequence_trigger_request_ff, nxt_sequence_trigger_request;
	// started_ff blocks a second start while sequence_trigger_request waits for sampling
	logic started_ff, nxt_started;
	// registered copies of every top output
	logic [ACFC_REG_W-1:0] rd_data_ff, nxt_rd_data;
	logic [ACFC_ERR_W-1:0] err_ff, nxt_err;
	logic seq_abort_cmd_ff, nxt_seq_abort_cmd;
	logic seq_start_ff, nxt_seq_start;
	logic fetch_top_ff, nxt_fetch_top;
	logic swap_list_ff, nxt_swap_list;
	// merged request terms, combinational
	logic bus_ok, hw_ok;
	logic abort_req, bus_abort, hw_abort, auto_abort;
	logic sequence_trigger_request_set, bus_sequence_trigger_request, hw_sequence_trigger_request;

	// one request term: a bus bit or an internal pulse, each gated by source
	function automatic logic merge_req(input logic bus_sel,
		input logic bus_bit, input logic hw_sel, input logic hw_bit);
		merge_req = (bus_sel & bus_bit) | (hw_sel & hw_bit);
	endfunction

	acfc_scenario_dec u_dec (
		.req(req)
	);

	// merge bus and internal requests per source selection
	always_comb begin
		bus_ok = request_source_select[ACFC_SRC_BUS] & wr_en; // [R4]
		hw_ok = request_source_select[ACFC_SRC_HW]; // [R4]
		// a zero in a written bit is simply no request
		bus_abort = bus_ok & wr_data[ACFC_BIT_ABORT]; // [R5]
		bus_sequence_trigger_request = bus_ok & wr_data[ACFC_BIT_SEQUENCE_TRIGGER_REQUEST]; // [R5]
		// internal pulses share the clock, so no synchroniser is needed
		hw_abort = hw_ok & sequence_abort_request;
		hw_sequence_trigger_request = hw_ok & sequence_trigger_request;
		abort_req = bus_abort | hw_abort;
		// hand the merged view to the decoder
		req.abort = abort_req;
		req.trigger = bus_sequence_trigger_request | hw_sequence_trigger_request;
		req.restart = merge_req(bus_ok, wr_data[ACFC_BIT_RESTART],
			hw_ok, list_restart_request);
		req.load_ok = merge_req(bus_ok, wr_data[ACFC_BIT_LOAD_OK],
			hw_ok, list_load_ok);
		req.trigger_mode = trigger_mode;
		// explicit abort or one already running means no automatic one
		auto_abort = req.restart & ~abort_req & ~abort_ff
			& ~abort_in_progress & ~end_of_list_reached; // [R8] [R17]
		sequence_trigger_request_set = req.take_trigger | req.auto_trigger; // [R18]
	end

	// abort and trigger bits, sequencing pulses, sticky error flags
	always_comb begin
		nxt_abort = abort_ff;
		nxt_aborted = aborted_ff;
		nxt_sequence_trigger_request = sequence_trigger_request_ff;
		nxt_started = started_ff;
		// set wins over clear for every sticky error flag
		nxt_err = err_ff & ~err_clr;
		// pulses default low; seq_abort_cmd and seq_start last one cycle, fetch_top one per restart cycle, swap_list one per restart cycle with load_ok
		nxt_seq_abort_cmd = 1'b0;
		nxt_seq_start = 1'b0;
		nxt_fetch_top = 1'b0;
		nxt_swap_list = 1'b0;
		// disable wins over everything, including requests this cycle
		if (!adc_en) begin
			nxt_abort = 1'b0; // [R3]
			nxt_aborted = 1'b0;
			nxt_sequence_trigger_request = 1'b0; // [R3]
			nxt_started = 1'b0;
		end else begin

			// abort: cut at the next boundary, then wait for idle
			if (abort_ff && !aborted_ff && conv_boundary) begin
				nxt_seq_abort_cmd = 1'b1; // [R1]
				nxt_aborted = 1'b1;
			end
			if (abort_ff && aborted_ff && conv_idle) begin
				nxt_abort = 1'b0; // [R2]
				nxt_aborted = 1'b0;
			end
			// set wins over the release above
			if (abort_req || auto_abort) begin
				nxt_abort = 1'b1; // [R8]
			end

			// overruns look at the old bit: a request while it is set
			if (abort_ff && bus_abort) begin
				nxt_err[ACFC_ERR_ABORT_OVR] = 1'b1; // [R6]
			end
			if (abort_ff && hw_abort) begin
				nxt_err[ACFC_ERR_ABORT_OVR] = 1'b1; // [R7]
			end
			if (auto_abort) begin
				nxt_err[ACFC_ERR_RESTART] = 1'b1; // [R9]
			end

			// trigger: start once, hold until first sample
			if (sequence_trigger_request_ff && !started_ff && !seq_active && !abort_ff) begin
				nxt_seq_start = 1'b1; // [R10]
				nxt_started = 1'b1;
			end
			if (sequence_trigger_request_ff && first_sample) begin
				nxt_sequence_trigger_request = 1'b0; // [R11]
				nxt_started = 1'b0;
			end
			// a fresh set outranks the first-sample clear
			if (sequence_trigger_request_set) begin
				nxt_sequence_trigger_request = 1'b1;
			end

			// the trigger error collects both overruns and the mode clash
			if (sequence_trigger_request_ff && bus_sequence_trigger_request) begin
				nxt_err[ACFC_ERR_SEQUENCE_TRIGGER_REQUEST] = 1'b1; // [R12]
			end
			if (sequence_trigger_request_ff && hw_sequence_trigger_request) begin
				nxt_err[ACFC_ERR_SEQUENCE_TRIGGER_REQUEST] = 1'b1; // [R13]
			end
			if (req.trigger_error) begin
				nxt_err[ACFC_ERR_SEQUENCE_TRIGGER_REQUEST] = 1'b1; // [R14]
			end
			// load_ok alone is reported, never acted on
			if (req.load_ok_error) begin
				nxt_err[ACFC_ERR_LOAD_OK] = 1'b1; // [R15]
			end

			// restart reloads from top of command_list; swap first
			nxt_fetch_top = req.restart; // [R16]
			nxt_swap_list = req.restart & req.load_ok; // [R16]
		end

		// restart and load_ok are events and read back as zero
		nxt_rd_data = ACFC_REG_RESET;
		nxt_rd_data[ACFC_BIT_ABORT] = nxt_abort;
		nxt_rd_data[ACFC_BIT_SEQUENCE_TRIGGER_REQUEST] = nxt_sequence_trigger_request;
	end

	// outputs come straight from these flops, never from logic
	// register stage; sync reset to constants only
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			abort_ff <= 1'b0;
			aborted_ff <= 1'b0;
			sequence_trigger_request_ff <= 1'b0;
			started_ff <= 1'b0;
			rd_data_ff <= ACFC_REG_RESET;
			err_ff <= ACFC_ERR_RESET;
			seq_abort_cmd_ff <= 1'b0;
			seq_start_ff <= 1'b0;
			fetch_top_ff <= 1'b0;
			swap_list_ff <= 1'b0;
		end else begin
			abort_ff <= nxt_abort;
			aborted_ff <= nxt_aborted;
			sequence_trigger_request_ff <= nxt_sequence_trigger_request;
			started_ff <= nxt_started;
			rd_data_ff <= nxt_rd_data;
			err_ff <= nxt_err;
			seq_abort_cmd_ff <= nxt_seq_abort_cmd;
			seq_start_ff <= nxt_seq_start;
			fetch_top_ff <= nxt_fetch_top;
			swap_list_ff <= nxt_swap_list;
		end
	end

	// ports are plain wires onto the output flops
	assign rd_data = rd_data_ff;
	assign err_flags = err_ff;
	assign seq_abort_cmd = seq_abort_cmd_ff;
	assign seq_start = seq_start_ff;
	assign fetch_top = fetch_top_ff;
	assign swap_list = swap_list_ff;
endmodule

// ==== tb/acfc_properties.sv ====
`timescale 1ns/1ns
// watches only the top ports of the flow control block
module acfc_properties (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic adc_en,
	input wire logic [1:0] request_source_select,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic conv_boundary,
	input wire logic conv_idle,
	input wire logic seq_active,
	input wire logic [7:0] rd_data,
	input wire logic [3:0] err_flags,
	input wire logic seq_abort_cmd,
	input wire logic seq_start,
	input wire logic fetch_top,
	input wire logic swap_list
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_en_clears_bits: assert property (!adc_en |=> rd_data[7:6] == 2'h0)
		else $error("bits kept while disabled");
	a_abort_release: assert property ($fell(rd_data[7]) |->
		$past(conv_idle) || !$past(adc_en)) else $error("early abort release");
	a_abort_boundary: assert property ($rose(seq_abort_cmd) |->
		$past(conv_boundary && rd_data[7])) else $error("abort off boundary");
	a_start_cause: assert property ($rose(seq_start) |->
		$past(rd_data[6] && !seq_active)) else $error("bad sequence start");
	a_swap_fetch: assert property (swap_list |-> fetch_top)
		else $error("swap without fetch");
	a_sequence_trigger_request_overrun: assert property (adc_en && wr_en && wr_data[6] &&
		rd_data[6] && request_source_select[0] |=> err_flags[1])
		else $error("trigger overrun missed");
	a_abort_overrun: assert property (adc_en && wr_en && wr_data[7] &&
		rd_data[7] && request_source_select[0] |=> err_flags[3])
		else $error("abort overrun missed");
	a_restart_err: assert property ($rose(err_flags[0]) |-> rd_data[7])
		else $error("restart error without abort");
endmodule
bind acfc_flow_ctrl acfc_properties i_prop (.*);

// ==== tb/acfc_conv_model.sv ====
`timescale 1ns/1ns
// converter core stand-in: eight cycle sequence per start
module acfc_conv_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic seq_start,
	input wire logic seq_abort_cmd,
	output logic conv_idle,
	output logic seq_active,
	output logic first_sample,
	output logic conv_boundary
);
	logic [3:0] cnt_ff, nxt_cnt;
	logic [1:0] ph_ff;
	// abort wins over start so a cancelled sequence never lingers
	always_comb begin
		nxt_cnt = cnt_ff - {3'h0, |cnt_ff};
		if (seq_start)
			nxt_cnt = 4'h8;
		if (seq_abort_cmd)
			nxt_cnt = 4'h0;
	end
	always_ff @(posedge ref_clk) begin
		cnt_ff <= nrst ? nxt_cnt : 4'h0;
		ph_ff <= nrst ? ph_ff + 2'h1 : 2'h0;
	end
	// boundaries tick when idle too, so a pending abort always lands
	assign conv_boundary = ph_ff == 2'h3;
	assign seq_active = |cnt_ff;
	assign conv_idle = ~|cnt_ff;
	assign first_sample = cnt_ff == 4'h7;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench import acfc_pkg::*;;
	logic ref_clk = 1'h0, nrst = 1'h0, adc_en = 1'h0, wr_en = 1'h0;
	logic trigger_mode = 1'h0, eol = 1'h0;
	logic [1:0] src = 2'h1;
	logic [7:0] wr_data = 8'h00, rd_data;
	logic [3:0] hw = 4'h0, err_clr = 4'h0, err_flags;
	logic conv_idle, seq_active, first_sample, conv_boundary;
	logic seq_abort_cmd, seq_start, fetch_top, swap_list;
	logic [31:0] r;
	int failures = 0, total_checks = 0;
	acfc_flow_ctrl i_dut (.ref_clk, .nrst, .adc_en, .request_source_select(src),
		.trigger_mode, .wr_en, .wr_data, .sequence_abort_request(hw[3]),
		.sequence_trigger_request(hw[2]), .list_restart_request(hw[1]),
		.list_load_ok(hw[0]), .conv_boundary, .conv_idle, .seq_active,
		.first_sample, .abort_in_progress(1'h0), .end_of_list_reached(eol),
		.err_clr, .rd_data, .err_flags, .seq_abort_cmd, .seq_start,
		.fetch_top, .swap_list);
	acfc_conv_model i_conv (.ref_clk, .nrst, .seq_start, .seq_abort_cmd,
		.conv_idle, .seq_active, .first_sample, .conv_boundary);
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// the leading edge keeps back to back calls from retoggling a strobe
	task automatic bus(input logic [7:0] d);
		@(negedge ref_clk);
		wr_en = 1'h1;
		wr_data = d;
		@(negedge ref_clk);
		wr_en = 1'h0;
	endtask
	task automatic req(input logic [3:0] p);
		@(negedge ref_clk);
		hw = p;
		@(negedge ref_clk);
		hw = 4'h0;
	endtask
	// bounded wait for both bits to drop, then wipe the sticky flags
	task automatic idle();
		int n;
		for (n = 0; n < 40 && rd_data[7:6] !== 2'h0; n++)
			@(negedge ref_clk);
		chk(rd_data, 8'h00);
		err_clr = 4'hF;
		@(negedge ref_clk);
		err_clr = 4'h0;
	endtask
	task automatic conclude();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	// generous: the whole run needs well under 1000 cycles
	initial begin
		#400000;
		failures++;
		conclude();
	end
	initial begin
		void'($urandom(56));
		repeat (6) @(negedge ref_clk);
		nrst = 1'h1;
		chk(rd_data, ACFC_REG_RESET);
		bus(8'hC0);
		chk(rd_data, 8'h00);
		adc_en = 1'h1;
		src = 2'h2;
		bus(8'h40);
		chk(rd_data, 8'h00);
		src = 2'h3;
		bus(8'h40);
		chk(rd_data, 8'h40);
		@(negedge ref_clk);
		chk({7'h00, seq_start}, 8'h01);
		bus(8'h40);
		chk({4'h0, err_flags}, 8'h02);
		idle();
		bus(8'h80);
		bus(8'h80);
		chk({4'h0, err_flags}, 8'h08);
		idle();
		req(4'h8);
		req(4'h8);
		chk({4'h0, err_flags}, 8'h08);
		idle();
		req(4'h6);
		chk({rd_data[7:6], 2'h0, err_flags}, 8'h83);
		idle();
		trigger_mode = 1'h1;
		req(4'h3);
		chk({fetch_top, swap_list, rd_data[7:6]}, 8'h0F);
		idle();
		req(4'hA);
		chk({4'h0, err_flags}, 8'h00);
		idle();
		req(4'h1);
		chk({4'h0, err_flags}, 8'h04);
		idle();
		// any internal request mix that includes restart is driven when r[1] is set; bus writes never pair abort with trigger
		repeat (300) begin
			r = $urandom;
			hw = r[1] ? r[3:0] : {r[3], r[2] & !r[3], 2'h0};
			wr_en = r[4];
			wr_data = {r[15], r[14] & !r[15], 6'h00};
			src = r[17:16];
			trigger_mode = r[18];
			eol = r[19];
			err_clr = r[23:20];
			@(negedge ref_clk);
		end
		{hw, wr_en, adc_en} = 6'h00;
		@(negedge ref_clk);
		chk(rd_data, 8'h00);
		conclude();
	end
endmodule
